// ==== scg_chan_filter.sv ====
module scg_chan_filter (
  // filter config and frame header
  scg_filt_if.flt fif
);

  logic is_bc;
  logic is_mc;
  logic uc_hit;
  logic addr_ok;
  logic vlan_ok;

  // ****************************************
  // address and vlan filters
  // ****************************************
  always_comb
  begin
    is_bc   = (fif.dst == scg_pkg::BCAST_MAC);
    is_mc   = fif.dst[scg_pkg::MCAST_BIT] && !is_bc;
    uc_hit  = fif.mac_ok && (fif.dst == fif.mac);
    if (is_bc)
      addr_ok = fif.bc_acc;
    else if (is_mc)
      addr_ok = fif.mc_all || uc_hit;
    else
      addr_ok = uc_hit;
    // mode 1 drops untagged frames
    if (!fif.vlan_en)
      vlan_ok = 1'b1;
    else if (fif.tag)
      vlan_ok = (fif.tvid == fif.vid);
    else
      vlan_ok = !fif.vlan_mode;
  end

  assign fif.acc     = addr_ok && vlan_ok;
  assign fif.src_hit = fif.mac_ok && (fif.src == fif.mac);

endmodule

// ==== scg_filt_if.sv ====
interface scg_filt_if;
  logic [47:0] mac;
  logic        mac_ok;
  logic        bc_acc;
  logic        mc_all;
  logic        vlan_en;
  logic        vlan_mode;
  logic [11:0] vid;
  logic [47:0] src;
  logic [47:0] dst;
  logic        tag;
  logic [11:0] tvid;
  logic        src_hit;
  logic        acc;
  modport cfg (output mac, mac_ok, bc_acc, mc_all, vlan_en, vlan_mode, vid,
               output src, dst, tag, tvid, input src_hit, acc);
  modport flt (input mac, mac_ok, bc_acc, mc_all, vlan_en, vlan_mode, vid,
               input src, dst, tag, tvid, output src_hit, acc);
endinterface

// ==== scg_gate.sv ====
// Chosen here: the placing of the registers and the plain strobed port.
module scg_gate (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  // register port
  input  wire logic [scg_pkg::ADDR_W-1:0]    addr,
  input  wire logic [31:0]                   wdata,
  input  wire logic                          wr_stb,
  input  wire logic                          rd_stb,
  output logic      [31:0]                   rdata,
  // package id level
  input  wire logic [2:0]                    pkg_id_strap,
  // frames from the controller over the sideband
  input  wire logic                          sb_rx_valid,
  input  wire logic                          sb_rx_is_ctl,
  input  wire logic [47:0]                   sb_rx_src_mac,
  output logic                               net_tx_fwd,
  output logic      [scg_pkg::CH_IW-1:0]     net_tx_ch,
  // frames from the network
  input  wire logic                          net_rx_valid,
  input  wire logic [scg_pkg::CH_IW-1:0]     net_rx_ch,
  input  wire logic [47:0]                   net_rx_dst_mac,
  input  wire logic                          net_rx_vlan_tag,
  input  wire logic [11:0]                   net_rx_vlan_id,
  output logic                               sb_tx_fwd,
  output logic      [scg_pkg::CH_IW-1:0]     sb_tx_ch,
  // events
  input  wire logic                          aen_req_valid,
  input  wire logic [scg_pkg::CH_IW-1:0]     aen_req_ch,
  input  wire logic [1:0]                    aen_req_type,
  output logic                               aen_send,
  output logic      [scg_pkg::CH_IW-1:0]     aen_ch,
  output logic      [1:0]                    aen_type,
  // status
  output logic                               rsp_send,
  output logic                               pkg_selected,
  output logic                               flow_ctl_en,
  output logic                               cmd_ready
);

  localparam int NCH   = scg_pkg::NUM_CH;
  localparam int CIW   = scg_pkg::CH_IW;
  localparam int TW    = scg_pkg::TMR_W;
  localparam int RDY   = scg_pkg::READY_CYC;
  localparam int RDY_A = scg_pkg::READY_CYC + 1;
  typedef struct packed {
    logic                          ready;
    logic [TW-1:0]                 tmr;
    logic [2:0]                    pkg;
    logic                          sel;
    logic                          hw_arb;
    logic                          flow;
    logic [NCH-1:0]                ch_en;
    logic [NCH-1:0]                ntx_en;
    logic [NCH-1:0]                init;
    logic [NCH-1:0]                bc_acc;
    logic [NCH-1:0]                mc_all;
    logic [NCH-1:0]                vlan_en;
    logic [NCH-1:0]                vlan_mode;
    logic [NCH-1:0]                mac_ok;
    logic [NCH-1:0][47:0]          mac;
    logic [NCH-1:0][11:0]          vid;
    logic [NCH-1:0][scg_pkg::AEN_N-1:0] aen_en;
    logic [31:0]                   arg_lo;
    logic [15:0]                   arg_hi;
    logic                          rsp_v;
    logic [7:0]                    rsp_op;
    logic [7:0]                    rsp_ch;
    logic [7:0]                    rsp_code;
    logic [31:0]                   rsp_dat;
    logic                          rsp_p;
    logic                          ntx_p;
    logic [CIW-1:0]                ntx_ch;
    logic                          sbtx_p;
    logic [CIW-1:0]                sbtx_ch;
    logic                          aen_p;
    logic [CIW-1:0]                aen_ch;
    logic [1:0]                    aen_ty;
    logic [31:0]                   rdata;
  } scg_state_t;
  scg_state_t       s_r;
  scg_state_t       s_nxt;
  scg_pkg::scg_op_t op;
  logic [7:0]       cid;
  logic [7:0]       prm;
  logic [CIW-1:0]   ci;
  logic             pw;
  logic             cmd_go;
  logic             cmd_hit;
  logic             pkg_op;
  logic [NCH-1:0]   src_hit;
  logic [NCH-1:0]   acc;
  logic [NCH-1:0]   ntx_hit;
  logic             ntx_go;
  logic             rx_go;
  logic             aen_go;

  // ****************************************
  // per channel filters
  // ****************************************
  scg_filt_if fif[NCH] ();

  generate
    for (genvar g = 0; g < NCH; g++)
    begin : g_ch
      assign fif[g].mac       = s_r.mac[g];
      assign fif[g].mac_ok    = s_r.mac_ok[g];
      assign fif[g].bc_acc    = s_r.bc_acc[g];
      assign fif[g].mc_all    = s_r.mc_all[g];
      assign fif[g].vlan_en   = s_r.vlan_en[g];
      assign fif[g].vlan_mode = s_r.vlan_mode[g];
      assign fif[g].vid       = s_r.vid[g];
      assign fif[g].src       = sb_rx_src_mac;
      assign fif[g].dst       = net_rx_dst_mac;
      assign fif[g].tag       = net_rx_vlan_tag;
      assign fif[g].tvid      = net_rx_vlan_id;
      assign src_hit[g]       = fif[g].src_hit;
      assign acc[g]           = fif[g].acc;
      scg_chan_filter u_filt (
        .fif (fif[g])
      );
    end
  endgenerate

  // ****************************************
  // command decode
  // ****************************************
  assign op     = scg_pkg::scg_op_t'(wdata[7:0]);
  assign cid    = wdata[15:8];
  assign prm    = wdata[23:16];
  assign ci     = cid[CIW-1:0];
  assign pw     = (cid[4:0] == scg_pkg::ICH_PKG);
  assign cmd_go = wr_stb && (addr == scg_pkg::OFF_CMD) && s_r.ready;
  // absent ids stay silent
  assign cmd_hit = cmd_go && (cid[7:5] == s_r.pkg)
                   && (pw || (cid[4:0] < 5'(NCH)));
  assign pkg_op = (op == scg_pkg::OP_SEL) || (op == scg_pkg::OP_DESEL)
                  || (op == scg_pkg::OP_FLOW);

  // ****************************************
  // traffic gating
  // ****************************************
  assign ntx_hit = src_hit & s_r.ntx_en;
  assign ntx_go  = sb_rx_valid && !sb_rx_is_ctl && (|ntx_hit);
  assign rx_go   = net_rx_valid && s_r.sel && s_r.ch_en[net_rx_ch]
                   && acc[net_rx_ch];
  assign aen_go  = aen_req_valid && s_r.sel && s_r.ch_en[aen_req_ch]
                   && s_r.aen_en[aen_req_ch][aen_req_type];

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    s_nxt        = s_r;
    s_nxt.rsp_p  = 1'b0;
    s_nxt.ntx_p  = 1'b0;
    s_nxt.sbtx_p = 1'b0;
    s_nxt.aen_p  = 1'b0;
    s_nxt.rdata  = 32'h0000_0000;
    // ready interval; package id taken while it runs
    if (!s_r.ready)
    begin
      s_nxt.pkg = pkg_id_strap;
      if (s_r.tmr == TW'(RDY))
        s_nxt.ready = 1'b1;
      else
        s_nxt.tmr = s_r.tmr + 1'b1;
    end
    if (wr_stb && (addr == scg_pkg::OFF_ARG_LO))
      s_nxt.arg_lo = wdata;
    if (wr_stb && (addr == scg_pkg::OFF_ARG_HI))
      s_nxt.arg_hi = wdata[15:0];
    if (rd_stb)
    begin
      case (addr)
        scg_pkg::OFF_ARG_LO:   s_nxt.rdata = s_r.arg_lo;
        scg_pkg::OFF_ARG_HI:   s_nxt.rdata = {16'h0000, s_r.arg_hi};
        scg_pkg::OFF_RSP:
        begin
          s_nxt.rdata = {s_r.rsp_code, s_r.rsp_ch, s_r.rsp_op,
                         7'h00, s_r.rsp_v};
          s_nxt.rsp_v = 1'b0;
        end
        scg_pkg::OFF_RSP_DATA: s_nxt.rdata = s_r.rsp_dat;
        scg_pkg::OFF_STAT:
          s_nxt.rdata = {13'h0000, s_r.pkg, 2'h0, s_r.init, s_r.ntx_en,
                         s_r.ch_en, 4'h0, s_r.flow, s_r.hw_arb, s_r.sel,
                         s_r.ready};
        default:               s_nxt.rdata = 32'h0000_0000;
      endcase
    end
    // response after any read clear, so a new answer wins
    if (cmd_hit)
    begin
      s_nxt.rsp_p    = 1'b1;
      s_nxt.rsp_v    = 1'b1;
      s_nxt.rsp_op   = wdata[7:0];
      s_nxt.rsp_ch   = cid;
      s_nxt.rsp_code = scg_pkg::RC_OK;
      s_nxt.rsp_dat  = 32'h0000_0000;
      if (op != scg_pkg::OP_DESEL)
        s_nxt.sel = 1'b1;
      if (pkg_op)
      begin
        if (!pw)
          s_nxt.rsp_code = scg_pkg::RC_BAD_ID;
        else
        begin
          case (op)
            scg_pkg::OP_SEL:   s_nxt.hw_arb = prm[0];
            scg_pkg::OP_DESEL: s_nxt.sel = 1'b0;
            scg_pkg::OP_FLOW:  s_nxt.flow = prm[0];
            default:           s_nxt.rsp_code = scg_pkg::RC_UNSUP;
          endcase
        end
      end
      else if (pw)
        s_nxt.rsp_code = scg_pkg::RC_BAD_ID;
      else if (s_r.init[ci] && (op != scg_pkg::OP_CLR_INIT))
        s_nxt.rsp_code = scg_pkg::RC_INIT;
      else
      begin
        case (op)
          scg_pkg::OP_CLR_INIT: s_nxt.init[ci] = 1'b0;
          scg_pkg::OP_EN_CH:    s_nxt.ch_en[ci] = 1'b1;
          scg_pkg::OP_DIS_CH:   s_nxt.ch_en[ci] = 1'b0;
          scg_pkg::OP_EN_NTX:   s_nxt.ntx_en[ci] = 1'b1;
          scg_pkg::OP_DIS_NTX:  s_nxt.ntx_en[ci] = 1'b0;
          scg_pkg::OP_AEN_EN:   s_nxt.aen_en[ci] = prm[3:0];
          scg_pkg::OP_SET_MAC:
          begin
            s_nxt.mac[ci]    = {s_r.arg_hi, s_r.arg_lo};
            s_nxt.mac_ok[ci] = 1'b1;
          end
          scg_pkg::OP_EN_BC:    s_nxt.bc_acc[ci] = 1'b1;
          scg_pkg::OP_DIS_BC:   s_nxt.bc_acc[ci] = 1'b0;
          scg_pkg::OP_EN_MC:    s_nxt.mc_all[ci] = 1'b1;
          scg_pkg::OP_DIS_MC:   s_nxt.mc_all[ci] = 1'b0;
          scg_pkg::OP_SET_VID:  s_nxt.vid[ci] = s_r.arg_lo[11:0];
          scg_pkg::OP_EN_VLAN:
          begin
            s_nxt.vlan_en[ci]   = 1'b1;
            s_nxt.vlan_mode[ci] = prm[0];
          end
          scg_pkg::OP_DIS_VLAN: s_nxt.vlan_en[ci] = 1'b0;
          scg_pkg::OP_CAPS:
            s_nxt.rsp_dat = {23'h000000, scg_pkg::HWARB_SUP,
                             8'(NCH)};
          scg_pkg::OP_VER:      s_nxt.rsp_dat = scg_pkg::VERSION_ID;
          default:              s_nxt.rsp_code = scg_pkg::RC_UNSUP;
        endcase
      end
    end
    // lowest matching channel takes the frame
    if (ntx_go)
    begin
      s_nxt.ntx_p = 1'b1;
      for (int i = NCH - 1; i >= 0; i--)
        if (ntx_hit[i])
          s_nxt.ntx_ch = CIW'(i);
    end
    if (rx_go)
    begin
      s_nxt.sbtx_p  = 1'b1;
      s_nxt.sbtx_ch = net_rx_ch;
    end
    if (aen_go)
    begin
      s_nxt.aen_p  = 1'b1;
      s_nxt.aen_ch = aen_req_ch;
      s_nxt.aen_ty = aen_req_type;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_r      <= '0;
      s_r.init <= {NCH{1'b1}};
    end
    else
      s_r <= s_nxt;
  end

  // ****************************************
  // outputs
  // ****************************************
  assign rdata        = s_r.rdata;
  assign net_tx_fwd   = s_r.ntx_p;
  assign net_tx_ch    = s_r.ntx_ch;
  assign sb_tx_fwd    = s_r.sbtx_p;
  assign sb_tx_ch     = s_r.sbtx_ch;
  assign aen_send     = s_r.aen_p;
  assign aen_ch       = s_r.aen_ch;
  assign aen_type     = s_r.aen_ty;
  assign rsp_send     = s_r.rsp_p;
  assign pkg_selected = s_r.sel;
  assign flow_ctl_en  = s_r.flow;
  assign cmd_ready    = s_r.ready;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  wire aen_off_h = aen_req_valid && !s_r.aen_en[aen_req_ch][aen_req_type];
  wire absent_h  = cmd_go && (cid[7:5] != s_r.pkg);
  wire desel_h   = cmd_hit && pw && (op == scg_pkg::OP_DESEL);
  chk_unsel_quiet: assert property (
    !s_r.sel [*2] |-> !aen_send && !sb_tx_fwd)
    else $error("unrequested traffic while deselected");
  chk_dis_quiet: assert property (
    aen_req_valid && !s_r.ch_en[aen_req_ch] |=> !aen_send)
    else $error("event sent from disabled channel");
  chk_rsp_always: assert property (cmd_hit |=> rsp_send)
    else $error("response missing after command");
  chk_rsp_cause: assert property (!cmd_hit |=> !rsp_send)
    else $error("response without a command");
  chk_ntx_gate: assert property (
    net_tx_fwd |-> $past(ntx_go) && $past(sb_rx_valid))
    else $error("pass-through sent to network without cause");
  chk_aen_type: assert property (aen_off_h |=> !aen_send)
    else $error("disabled event type generated");
  chk_rx_fwd: assert property (
    rx_go |=> sb_tx_fwd && (sb_tx_ch == $past(net_rx_ch)))
    else $error("filtered frame not forwarded");
  chk_rx_drop: assert property (
    net_rx_valid && !acc[net_rx_ch] |=> !sb_tx_fwd)
    else $error("rejected frame forwarded");
  chk_ready_time: assert property (
    !s_r.ready |-> ##[0:RDY_A] s_r.ready)
    else $error("ready interval too long");
  chk_absent_id: assert property (absent_h |=> !rsp_send)
    else $error("response to absent package id");
  chk_desel_drop: assert property (desel_h |=> !pkg_selected)
    else $error("package still selected after deselect");
  cov_cmd_rsp:  cover property (cmd_hit ##1 rsp_send);
  cov_ntx_fwd:  cover property (net_tx_fwd);
  cov_sb_fwd:   cover property (sb_tx_fwd ##1 sb_tx_fwd);
  cov_aen_sent: cover property (aen_send);

endmodule

// ==== scg_mc_model.sv ====
module scg_mc_model (
  // clock
  input  wire logic        clk,
  // register port
  output logic [7:0]       addr,
  output logic [31:0]      wdata,
  output logic             wr_stb,
  output logic             rd_stb,
  input  wire logic [31:0] rdata,
  input  wire logic        rsp_send,
  // sideband frames
  output logic             sb_rx_valid,
  output logic             sb_rx_is_ctl,
  output logic [47:0]      sb_rx_src_mac
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    addr          = 8'h00;
    wdata         = 32'h0;
    wr_stb        = 1'h0;
    rd_stb        = 1'h0;
    sb_rx_valid   = 1'h0;
    sb_rx_is_ctl  = 1'h0;
    sb_rx_src_mac = 48'h0;
  end

  // ****************************************
  // register bus cycles
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr   <= a;
    wdata  <= v;
    wr_stb <= 1'h1;
    @(posedge clk);
    wr_stb <= 1'h0;
    addr   <= ~a;
    wdata  <= ~v;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr   <= a;
    rd_stb <= 1'h1;
    @(posedge clk);
    rd_stb <= 1'h0;
    addr   <= ~a;
    #1 v = rdata;
  endtask

  // silence is a legal outcome, so got may stay low
  task automatic cmd(input logic [7:0] op, id, prm, output logic got);
    wr(scg_pkg::OFF_CMD, {8'h00, prm, id, op});
    #1 got = rsp_send;
  endtask

  task automatic frame(input logic ctl, input logic [47:0] src);
    @(posedge clk);
    sb_rx_valid   <= 1'h1;
    sb_rx_is_ctl  <= ctl;
    sb_rx_src_mac <= src;
    @(posedge clk);
    sb_rx_valid   <= 1'h0;
    sb_rx_src_mac <= ~src;
  endtask

  // ****************************************
  // package discovery
  // ****************************************
  task automatic discover(output int found);
    logic got;
    found = -1;
    for (int p = 0; p < 8 && found < 0; p++)
      for (int t = 0; t < 3 && found < 0; t++)
      begin
        cmd(scg_pkg::OP_SEL, {3'(p), 5'h1F}, 8'h00, got);
        if (got)
          found = p;
      end
  endtask
endmodule

// ==== scg_pkg.sv ====
package scg_pkg;

  // ****************************************
  // sizes
  // ****************************************
  localparam int NUM_CH = 2;
  localparam int CH_IW  = 1;
  localparam int AEN_N  = 4;
  localparam int ADDR_W = 8;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] OFF_CMD      = 8'h00;
  localparam logic [7:0] OFF_ARG_LO   = 8'h04;
  localparam logic [7:0] OFF_ARG_HI   = 8'h08;
  localparam logic [7:0] OFF_RSP      = 8'h0C;
  localparam logic [7:0] OFF_RSP_DATA = 8'h10;
  localparam logic [7:0] OFF_STAT     = 8'h14;

  // ****************************************
  // channel id fields and response codes
  // ****************************************
  localparam logic [4:0] ICH_PKG    = 5'h1F;
  localparam logic [7:0] RC_OK      = 8'h00;
  localparam logic [7:0] RC_BAD_ID  = 8'h01;
  localparam logic [7:0] RC_INIT    = 8'h02;
  localparam logic [7:0] RC_UNSUP   = 8'h03;
  localparam logic       HWARB_SUP  = 1'h1;
  // arbitrary value
  localparam logic [31:0] VERSION_ID = 32'h0000_0A01;
  localparam logic [47:0] BCAST_MAC  = 48'hFFFF_FFFF_FFFF;
  localparam int          MCAST_BIT  = 40;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_NS    = 10;
  localparam int READY_NS  = 2000;
  localparam int READY_CYC = (READY_NS / CLK_NS < 1) ? 1 : READY_NS / CLK_NS;
  localparam int TMR_W     = $clog2(READY_CYC + 1);

  typedef enum logic [7:0] {
    OP_CLR_INIT = 8'h00, OP_SEL     = 8'h01, OP_DESEL   = 8'h02,
    OP_EN_CH    = 8'h03, OP_DIS_CH  = 8'h04, OP_EN_NTX  = 8'h05,
    OP_DIS_NTX  = 8'h06, OP_AEN_EN  = 8'h07, OP_SET_MAC = 8'h08,
    OP_EN_BC    = 8'h09, OP_DIS_BC  = 8'h0A, OP_EN_MC   = 8'h0B,
    OP_DIS_MC   = 8'h0C, OP_SET_VID = 8'h0D, OP_EN_VLAN = 8'h0E,
    OP_DIS_VLAN = 8'h0F, OP_FLOW    = 8'h10, OP_CAPS    = 8'h11,
    OP_VER      = 8'h12
  } scg_op_t;

endpackage

// ==== tb.sv ====
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // signals
  // ****************************************
  logic        clk;
  logic        rst_n;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr_stb;
  logic        rd_stb;
  logic [31:0] rdata;
  logic [2:0]  pkg_id_strap;
  logic        sb_rx_valid;
  logic        sb_rx_is_ctl;
  logic [47:0] sb_rx_src_mac;
  logic        net_tx_fwd;
  logic [0:0]  net_tx_ch;
  logic        net_rx_valid;
  logic [0:0]  net_rx_ch;
  logic [47:0] net_rx_dst_mac;
  logic        net_rx_vlan_tag;
  logic [11:0] net_rx_vlan_id;
  logic        sb_tx_fwd;
  logic [0:0]  sb_tx_ch;
  logic        aen_req_valid;
  logic [0:0]  aen_req_ch;
  logic [1:0]  aen_req_type;
  logic        aen_send;
  logic [0:0]  aen_ch;
  logic [1:0]  aen_type;
  logic        rsp_send;
  logic        pkg_selected;
  logic        flow_ctl_en;
  logic        cmd_ready;
  int          err_total;
  int          total_checks;
  int          found;
  int          n;
  logic        got;
  logic [31:0] d;

  localparam logic [47:0] MAC = 48'h0200_0000_0001;
  localparam logic [47:0] MC  = 48'h0100_0000_0005;
  localparam logic [47:0] BC  = scg_pkg::BCAST_MAC;

  typedef struct packed {
    logic [7:0] op;
    logic [7:0] id;
    logic [7:0] prm;
    logic       rsp;
    logic [7:0] code;
  } scg_row_t;

  // command, target, param, answered, response code
  scg_row_t rows [16] = '{
    '{8'h08, 8'h40, 8'h00, 1'h1, 8'h02},
    '{8'h00, 8'h40, 8'h00, 1'h1, 8'h00},
    '{8'h00, 8'h41, 8'h00, 1'h1, 8'h00},
    '{8'h00, 8'h42, 8'h00, 1'h0, 8'h00},
    '{8'h00, 8'h20, 8'h00, 1'h0, 8'h00},
    '{8'h01, 8'h40, 8'h00, 1'h1, 8'h01},
    '{8'h03, 8'h5F, 8'h00, 1'h1, 8'h01},
    '{8'h20, 8'h40, 8'h00, 1'h1, 8'h03},
    '{8'h08, 8'h40, 8'h00, 1'h1, 8'h00},
    '{8'h05, 8'h40, 8'h00, 1'h1, 8'h00},
    '{8'h03, 8'h40, 8'h00, 1'h1, 8'h00},
    '{8'h07, 8'h40, 8'h05, 1'h1, 8'h00},
    '{8'h10, 8'h5F, 8'h01, 1'h1, 8'h00},
    '{8'h09, 8'h40, 8'h00, 1'h1, 8'h00},
    '{8'h11, 8'h40, 8'h00, 1'h1, 8'h00},
    '{8'h12, 8'h40, 8'h00, 1'h1, 8'h00}
  };

  scg_gate dut (
    .clk, .rst_n, .addr, .wdata, .wr_stb, .rd_stb, .rdata, .pkg_id_strap,
    .sb_rx_valid, .sb_rx_is_ctl, .sb_rx_src_mac, .net_tx_fwd, .net_tx_ch,
    .net_rx_valid, .net_rx_ch, .net_rx_dst_mac, .net_rx_vlan_tag,
    .net_rx_vlan_id, .sb_tx_fwd, .sb_tx_ch, .aen_req_valid, .aen_req_ch,
    .aen_req_type, .aen_send, .aen_ch, .aen_type, .rsp_send, .pkg_selected,
    .flow_ctl_en, .cmd_ready
  );

  scg_mc_model mc (
    .clk, .addr, .wdata, .wr_stb, .rd_stb, .rdata, .rsp_send,
    .sb_rx_valid, .sb_rx_is_ctl, .sb_rx_src_mac
  );

  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input logic [47:0] got_v, input logic [47:0] exp_v);
    total_checks++;
    if (got_v !== exp_v)
    begin
      err_total++;
      $display("unexpected at %0t: got %0h want %0h", $time, got_v, exp_v);
    end
  endtask

  task automatic print_verdict();
    if (err_total == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic cm(input logic [7:0] op, id, prm);
    mc.cmd(op, id, prm, got);
    chk(got, 1'h1);
  endtask

  task automatic pt(input logic ctl, input logic [47:0] src, input logic e);
    mc.frame(ctl, src);
    #1 chk(net_tx_fwd, e);
    if (e)
      chk(net_tx_ch, 1'h0);
  endtask

  task automatic nf(input logic c, input logic [47:0] dst, input logic tg,
                    input logic [11:0] vid, input logic e);
    @(posedge clk);
    net_rx_valid    <= 1'h1;
    net_rx_ch       <= c;
    net_rx_dst_mac  <= dst;
    net_rx_vlan_tag <= tg;
    net_rx_vlan_id  <= vid;
    @(posedge clk);
    net_rx_valid    <= 1'h0;
    #1 chk(sb_tx_fwd, e);
    if (e)
      chk(sb_tx_ch, c);
  endtask

  task automatic ev(input logic c, input logic [1:0] t, input logic e);
    @(posedge clk);
    aen_req_valid <= 1'h1;
    aen_req_ch    <= c;
    aen_req_type  <= t;
    @(posedge clk);
    aen_req_valid <= 1'h0;
    #1 chk(aen_send, e);
    if (e)
      chk({aen_ch, aen_type}, {c, t});
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    rst_n           = 1'h0;
    pkg_id_strap    = 3'h2;
    net_rx_valid    = 1'h0;
    net_rx_ch       = 1'h0;
    net_rx_dst_mac  = 48'h0;
    net_rx_vlan_tag = 1'h0;
    net_rx_vlan_id  = 12'h000;
    aen_req_valid   = 1'h0;
    aen_req_ch      = 1'h0;
    aen_req_type    = 2'h0;
    err_total       = 0;
    total_checks    = 0;
    repeat (16) @(posedge clk);
    chk({cmd_ready, pkg_selected, rsp_send}, 3'h0);
    rst_n <= 1'h1;
    mc.cmd(8'h00, 8'h40, 8'h00, got);
    chk(got, 1'h0);
    n = 0;
    while (n < 400 && cmd_ready !== 1'h1)
    begin
      @(posedge clk);
      n++;
    end
    if (cmd_ready !== 1'h1)
      err_total++;
    chk(n > 150, 1'h1);
    pkg_id_strap <= 3'h5;
    mc.rd(scg_pkg::OFF_STAT, d);
    chk(d & 32'h0007_0F0F, 32'h0002_0001);
    mc.rd(8'h18, d);
    chk(d, 32'h0);
    mc.discover(found);
    chk(found, 2);
    mc.wr(scg_pkg::OFF_ARG_LO, 32'h0000_0001);
    mc.wr(scg_pkg::OFF_ARG_HI, 32'h0000_0200);
    mc.rd(scg_pkg::OFF_ARG_HI, d);
    chk(d, 32'h0000_0200);
    foreach (rows[i])
    begin
      mc.cmd(rows[i].op, rows[i].id, rows[i].prm, got);
      chk(got, rows[i].rsp);
      if (rows[i].rsp)
      begin
        mc.rd(scg_pkg::OFF_RSP, d);
        chk(d & 32'hFFFF_FF01, {rows[i].code, rows[i].id, rows[i].op, 8'h01});
      end
    end
    mc.rd(scg_pkg::OFF_RSP, d);
    chk(d[0], 1'h0);
    mc.rd(scg_pkg::OFF_RSP_DATA, d);
    chk(d, scg_pkg::VERSION_ID);
    cm(8'h11, 8'h40, 8'h00);
    mc.rd(scg_pkg::OFF_RSP_DATA, d);
    chk(d, 32'h0000_0102);
    chk(flow_ctl_en, 1'h1);
    mc.rd(scg_pkg::OFF_STAT, d);
    chk(d & 32'h0007_0F0F, 32'h0002_050B);
    cm(8'h08, 8'h41, 8'h00);
    pt(1'h0, MAC, 1'h1);
    pt(1'h1, MAC, 1'h0);
    pt(1'h0, MAC ^ 48'h1, 1'h0);
    nf(1'h0, MAC, 1'h0, 12'h000, 1'h1);
    nf(1'h0, MAC ^ 48'h10, 1'h0, 12'h000, 1'h0);
    nf(1'h1, MAC, 1'h0, 12'h000, 1'h0);
    nf(1'h0, BC, 1'h0, 12'h000, 1'h1);
    nf(1'h0, MC, 1'h0, 12'h000, 1'h0);
    cm(8'h0B, 8'h40, 8'h00);
    nf(1'h0, MC, 1'h0, 12'h000, 1'h1);
    cm(8'h0A, 8'h40, 8'h00);
    nf(1'h0, BC, 1'h0, 12'h000, 1'h0);
    mc.wr(scg_pkg::OFF_ARG_LO, 32'h0000_0005);
    cm(8'h0D, 8'h40, 8'h00);
    cm(8'h0E, 8'h40, 8'h01);
    nf(1'h0, MAC, 1'h1, 12'h005, 1'h1);
    nf(1'h0, MAC, 1'h1, 12'h006, 1'h0);
    nf(1'h0, MAC, 1'h0, 12'h000, 1'h0);
    cm(8'h0E, 8'h40, 8'h00);
    nf(1'h0, MAC, 1'h0, 12'h000, 1'h1);
    cm(8'h0F, 8'h40, 8'h00);
    nf(1'h0, MAC, 1'h1, 12'h006, 1'h1);
    for (int t = 0; t < 4; t++)
      ev(1'h0, 2'(t), 1'(8'h05 >> t));
    cm(8'h06, 8'h40, 8'h00);
    pt(1'h0, MAC, 1'h0);
    cm(8'h04, 8'h40, 8'h00);
    cm(8'h12, 8'h40, 8'h00);
    ev(1'h0, 2'h0, 1'h0);
    nf(1'h0, MAC, 1'h0, 12'h000, 1'h0);
    cm(8'h03, 8'h40, 8'h00);
    cm(8'h02, 8'h5F, 8'h00);
    chk(pkg_selected, 1'h0);
    ev(1'h0, 2'h0, 1'h0);
    cm(8'h01, 8'h5F, 8'h01);
    mc.rd(scg_pkg::OFF_STAT, d);
    chk(d[2:1], 2'h3);
    // reset in mid-run
    @(posedge clk);
    rst_n <= 1'h0;
    @(posedge clk);
    chk({cmd_ready, pkg_selected, flow_ctl_en, aen_send}, 4'h0);
    rst_n <= 1'h1;
    mc.cmd(8'h00, 8'h40, 8'h00, got);
    chk(got, 1'h0);
    mc.rd(scg_pkg::OFF_STAT, d);
    chk(d & 32'h0007_0F0F, 32'h0005_0000);
    print_verdict();
  end
endmodule
